// ===== src/instruction_cycle_timing.sv
// Timing side of the instruction sequencer: counts each instruction's cycles
`timescale 1ns/10ps
`default_nettype none
module instruction_cycle_timing #(
   // Core/debug dependent count; the default is arbitrary
   parameter logic [7:0] SVC_CYCLES = cycle_timing_pkg::CYC_SVC_DEFAULT
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Decoded instruction
   input wire logic i_issue,
   input wire cycle_timing_pkg::instr_class_t i_class,
   input wire logic [3:0] i_list_len,
   input wire logic i_taken,
   // Sequencer status
   output logic o_busy,
   output logic o_done,
   output logic [7:0] o_cycles,
   output logic o_bad_list
);
   import cycle_timing_pkg::*;

   // Refuse a zero supervisor count: the model needs at least one cycle
   if (SVC_CYCLES == 8'h00) begin : g_bad_svc
      $error("SVC_CYCLES must be at least one");
   end

   // Sequencer phases
   typedef enum logic [0:0] {ST_IDLE, ST_RUN} phase_t;

   // All state in one struct
   typedef struct packed {
      phase_t phase;        // Idle or executing
      logic [7:0] remain;   // Cycles left, current one included
      logic [7:0] total;    // Count of the instruction in flight
      logic done;           // Last cycle finished
      logic bad;            // List length out of range
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic [7:0] cost;        // Cycle count of the issuing instruction
   logic [7:0] list_ext;    // List length widened to the count width

   // Cost lookup for the class offered on the issue port
   always_comb begin
      list_ext = {4'h0, i_list_len};
      cost = CYC_SINGLE;
      unique case (i_class)
         CLS_ALU: cost = CYC_SINGLE;
         CLS_PC_WRITE: cost = CYC_FLUSH;
         CLS_ADDR_FORM: cost = CYC_SINGLE;
         CLS_SP_ARITH: cost = CYC_SINGLE;
         CLS_SHIFT: cost = CYC_SINGLE;
         CLS_LOAD: cost = CYC_MEMORY;
         CLS_STORE: cost = CYC_MEMORY;
         CLS_MULTI_XFER: cost = CYC_MULTI_BASE + list_ext;
         CLS_PUSH: cost = CYC_MULTI_BASE + list_ext;
         CLS_POP: cost = CYC_MULTI_BASE + list_ext;
         CLS_PUSH_LINK: cost = CYC_MULTI_BASE + list_ext;
         // N counts the program counter too
         CLS_POP_PC: cost = CYC_POP_PC_BASE + list_ext;
         CLS_BRANCH_COND: begin
            // Taken refills the pipeline, not taken falls through
            cost = i_taken ? CYC_FLUSH : CYC_SINGLE;
         end
         CLS_BRANCH: cost = CYC_FLUSH;
         CLS_BRANCH_LINK: cost = CYC_LINK;
         CLS_BRANCH_EXCH: cost = CYC_FLUSH;
         CLS_EXTEND: cost = CYC_SINGLE;
         CLS_REVERSE: cost = CYC_SINGLE;
         CLS_SPECIAL_REG: cost = CYC_SPECIAL;
         // Count comes from a parameter, not fixed here
         CLS_SUPERVISOR: cost = SVC_CYCLES;
         // Only execution cycles; the sleep itself is not timed
         CLS_WAIT_HINT: cost = CYC_WAIT;
         CLS_SIMPLE_HINT: cost = CYC_SINGLE;
         CLS_INT_MASK: cost = CYC_SINGLE;
         default: cost = CYC_SINGLE;  // Illegal class code runs as no-op
      endcase
   end

   // Next-state logic; counts assume zero-wait memory
   always_comb begin
      state_next = state_reg;
      state_next.done = 1'b0;
      unique case (state_reg.phase)
         ST_IDLE: begin
            // Issue is ignored unless idle or finishing
            if (i_issue) begin
               state_next.phase = ST_RUN;
               state_next.remain = cost;
               state_next.total = cost;
               state_next.bad = (i_list_len > LIST_MAX);
            end
         end
         ST_RUN: begin
            if (state_reg.remain == 8'h01) begin
               // Last cycle: report and accept a back-to-back issue
               state_next.done = 1'b1;
               state_next.phase = ST_IDLE;
               state_next.remain = CYC_IDLE;
               if (i_issue) begin
                  state_next.phase = ST_RUN;
                  state_next.remain = cost;
                  state_next.total = cost;
                  state_next.bad = (i_list_len > LIST_MAX);
               end
            end else begin
               state_next.remain = state_reg.remain - 8'h01;
            end
         end
      endcase
   end

   // State register with synchronous reset
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state_reg <= '{phase: ST_IDLE, remain: CYC_IDLE, total: CYC_IDLE,
                        done: 1'b0, bad: 1'b0};
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state flip-flops
   assign o_busy = (state_reg.phase == ST_RUN);
   assign o_done = state_reg.done;
   assign o_cycles = state_reg.total;
   assign o_bad_list = state_reg.bad;

endmodule : instruction_cycle_timing
`default_nettype wire

// ===== src/cycle_timing_pkg.sv
// Package of instruction classes and cycle counts for the sequencer timer
package cycle_timing_pkg;

   // Instruction classes as presented by the decoder
   typedef enum logic [4:0] {
      CLS_ALU,             // Moves, add, sub, compare, multiply, logic, rotate
      CLS_PC_WRITE,        // register_copy or add with program counter target
      CLS_ADDR_FORM,       // Address formed from program counter
      CLS_SP_ARITH,        // Stack pointer immediate and address forms
      CLS_SHIFT,           // Logical and arithmetic shifts
      CLS_LOAD,            // Single loads
      CLS_STORE,           // Single stores
      CLS_MULTI_XFER,      // load/store_multiple_registers
      CLS_PUSH,            // Push without link_register
      CLS_PUSH_LINK,       // Push with link_register
      CLS_POP,             // Pop without program counter
      CLS_POP_PC,          // Pop with program counter
      CLS_BRANCH_COND,     // Conditional branch
      CLS_BRANCH,          // Unconditional branch
      CLS_BRANCH_LINK,     // branch_with_link
      CLS_BRANCH_EXCH,     // branch_exchange and branch_link_exchange
      CLS_EXTEND,          // Sign or zero extensions
      CLS_REVERSE,         // Byte reversal forms
      CLS_SPECIAL_REG,     // special_register_read / special_register_write
      CLS_SUPERVISOR,      // supervisor_call
      CLS_WAIT_HINT,       // wait_for_event_hint / wait_for_interrupt_hint
      CLS_SIMPLE_HINT,     // send_event_hint, yield, no-operation
      CLS_INT_MASK         // Interrupt enable or disable
   } instr_class_t;

   // Cycle counts
   localparam logic [7:0] CYC_SINGLE = 8'h01;
   localparam logic [7:0] CYC_MEMORY = 8'h02;
   localparam logic [7:0] CYC_FLUSH = 8'h03;
   localparam logic [7:0] CYC_LINK = 8'h04;
   localparam logic [7:0] CYC_SPECIAL = 8'h04;
   localparam logic [7:0] CYC_WAIT = 8'h02;
   localparam logic [7:0] CYC_MULTI_BASE = 8'h01;
   localparam logic [7:0] CYC_POP_PC_BASE = 8'h04;
   localparam logic [7:0] CYC_SVC_DEFAULT = 8'h04;  // Configuration default
   localparam logic [7:0] CYC_IDLE = 8'h00;

   // Register list length width (up to 9 elements, return or link included)
   localparam int LIST_W = 4;
   localparam logic [3:0] LIST_MAX = 4'h9;

endpackage : cycle_timing_pkg

// ===== tb/cycle_timing_props.sv
// Checker of instruction cycle counts at the timer ports
`timescale 1ns/10ps
`default_nettype none
module cycle_timing_props
   import cycle_timing_pkg::*;
#(parameter logic [7:0] SVC_CYCLES = 8'h04) (
   // Clock, reset and decoded instruction
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_issue,
   input wire instr_class_t i_class,
   input wire logic [3:0] i_list_len,
   input wire logic i_taken,
   // Sequencer status
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic [7:0] o_cycles,
   input wire logic o_bad_list
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // Take from idle only: no earlier done can overlap the count
   wire logic go = i_issue && !o_busy;
   property p_one;
      go && i_class inside {CLS_ALU, CLS_ADDR_FORM, CLS_SP_ARITH, CLS_SHIFT,
         CLS_EXTEND, CLS_REVERSE, CLS_SIMPLE_HINT, CLS_INT_MASK}
      |=> o_busy && !o_done && o_cycles == 8'h01 ##1 o_done;
   endproperty
   a_one: assert property (p_one) else $error("one cycle");
   property p_two;
      go && i_class inside {CLS_LOAD, CLS_STORE, CLS_WAIT_HINT}
      |=> (o_busy && !o_done)[*2] ##1 o_done;
   endproperty
   a_two: assert property (p_two) else $error("two cycles");
   property p_three;
      go && i_class inside {CLS_PC_WRITE, CLS_BRANCH, CLS_BRANCH_EXCH}
      |=> (o_busy && !o_done)[*3] ##1 o_done;
   endproperty
   a_three: assert property (p_three) else $error("three cycles");
   property p_four;
      go && i_class inside {CLS_BRANCH_LINK, CLS_SPECIAL_REG}
      |=> (o_busy && !o_done)[*4] ##1 o_done;
   endproperty
   a_four: assert property (p_four) else $error("four cycles");
   property p_cond;
      go && i_class == CLS_BRANCH_COND
      |=> o_cycles == ($past(i_taken) ? 8'h03 : 8'h01);
   endproperty
   a_cond: assert property (p_cond) else $error("branch count");
   property p_multi;
      go && i_class inside {CLS_MULTI_XFER, CLS_PUSH, CLS_PUSH_LINK, CLS_POP}
      |=> o_cycles == 8'h01 + {4'h0, $past(i_list_len)};
   endproperty
   a_multi: assert property (p_multi) else $error("list count");
   property p_pop_pc;
      go && i_class == CLS_POP_PC
      |=> o_cycles == 8'h04 + {4'h0, $past(i_list_len)};
   endproperty
   a_pop_pc: assert property (p_pop_pc) else $error("return count");
   property p_svc;
      go && i_class == CLS_SUPERVISOR |=> o_cycles == SVC_CYCLES;
   endproperty
   a_svc: assert property (p_svc) else $error("call count");
endmodule : cycle_timing_props
bind instruction_cycle_timing cycle_timing_props #(.SVC_CYCLES(SVC_CYCLES))
   u_cycle_timing_props (.i_clock(i_clock), .i_nrst(i_nrst),
   .i_issue(i_issue), .i_class(i_class), .i_list_len(i_list_len),
   .i_taken(i_taken), .o_busy(o_busy), .o_done(o_done),
   .o_cycles(o_cycles), .o_bad_list(o_bad_list));
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the instruction cycle timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import cycle_timing_pkg::*;
   logic i_clock = 1'b0;
   logic i_nrst = 1'b0;
   logic i_issue = 1'b0;
   logic i_taken = 1'b0;
   instr_class_t i_class = CLS_ALU;
   logic [3:0] i_list_len = 4'h0;
   logic o_busy, o_done, o_bad_list;
   logic [7:0] o_cycles;
   int bad_count = 0;
   int check_count = 0;
   always #25 i_clock = ~i_clock;
   // Call count differs from default so a hard-wired value shows
   instruction_cycle_timing #(.SVC_CYCLES(8'h06)) u_instruction_cycle_timing (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_issue(i_issue),
      .i_class(i_class), .i_list_len(i_list_len), .i_taken(i_taken),
      .o_busy(o_busy), .o_done(o_done), .o_cycles(o_cycles),
      .o_bad_list(o_bad_list));
   // Compare and count
   task chk(input string s, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // One instruction from idle; busy span is counted, not trusted
   task run(input instr_class_t c, input logic [3:0] n, input logic t,
      input logic [7:0] e);
      int k;
      i_issue = 1'b1;
      i_class = c;
      i_list_len = n;
      i_taken = t;
      @(negedge i_clock);
      i_issue = 1'b0;
      k = 0;
      while (o_busy === 1'b1 && k < 300) begin
         k++;
         @(negedge i_clock);
      end
      chk("busy span", e, 8'(k));
      chk("count", e, o_cycles);
      chk("done", 8'h01, {7'h0, o_done});
      chk("bad list", {7'h0, n > 4'h9}, {7'h0, o_bad_list});
   endtask : run
   task t_fixed;
      run(CLS_ALU, 4'h0, 1'b0, 8'h01);
      run(CLS_ADDR_FORM, 4'h0, 1'b0, 8'h01);
      run(CLS_SP_ARITH, 4'h0, 1'b0, 8'h01);
      run(CLS_SHIFT, 4'h0, 1'b0, 8'h01);
      run(CLS_EXTEND, 4'h0, 1'b0, 8'h01);
      run(CLS_REVERSE, 4'h0, 1'b0, 8'h01);
      run(CLS_SIMPLE_HINT, 4'h0, 1'b0, 8'h01);
      run(CLS_LOAD, 4'h0, 1'b0, 8'h02);
      run(CLS_STORE, 4'h0, 1'b0, 8'h02);
      run(CLS_WAIT_HINT, 4'h0, 1'b0, 8'h02);
      run(CLS_PC_WRITE, 4'h0, 1'b0, 8'h03);
      run(CLS_SPECIAL_REG, 4'h0, 1'b0, 8'h04);
      run(CLS_SUPERVISOR, 4'h0, 1'b0, 8'h06);
      run(CLS_BRANCH_COND, 4'h0, 1'b1, 8'h03);
      run(CLS_BRANCH_COND, 4'h0, 1'b0, 8'h01);
      run(CLS_BRANCH, 4'h0, 1'b0, 8'h03);
      run(CLS_BRANCH_LINK, 4'h0, 1'b0, 8'h04);
      run(CLS_BRANCH_EXCH, 4'h0, 1'b0, 8'h03);
   endtask : t_fixed
   // List lengths up to one past the largest legal list
   task t_multi;
      for (int n = 0; n < 11; n++) begin
         run(CLS_PUSH, 4'(n), 1'b0, 8'(n + 1));
         run(CLS_POP_PC, 4'(n), 1'b0, 8'(n + 4));
      end
      run(CLS_PUSH_LINK, 4'h9, 1'b0, 8'h0a);
      run(CLS_MULTI_XFER, 4'h5, 1'b0, 8'h06);
      run(CLS_INT_MASK, 4'h0, 1'b0, 8'h01);
      run(CLS_POP, 4'h3, 1'b0, 8'h04);
   endtask : t_multi
   // Issue held early is ignored, then taken in the last busy cycle
   task t_back;
      i_issue = 1'b1;
      i_class = CLS_LOAD;
      @(negedge i_clock);
      i_class = CLS_ALU;
      @(negedge i_clock);
      chk("held count", 8'h02, o_cycles);
      @(negedge i_clock);
      i_issue = 1'b0;
      chk("overlap", 8'h01, {7'h0, o_done & o_busy});
      chk("next count", 8'h01, o_cycles);
      @(negedge i_clock);
      chk("end", 8'h01, {7'h0, o_done & ~o_busy});
   endtask : t_back
   initial begin
      repeat (5) @(negedge i_clock);
      i_nrst = 1'b1;
      t_fixed();
      t_multi();
      t_back();
      final_report();
   end
   // Whole run is a few hundred cycles; this is far beyond it
   initial begin
      #200000;
      bad_count++;
      final_report();
   end
   task final_report;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
endmodule : testbench
`default_nettype wire
